//--- rtl/quhbs_top.sv
// Purpose: Host bus front end of a four channel UART with two bus styles
// Assumes: Channel engines run on clk; host pins are asynchronous
// Notes:   All outputs are registered; data bus uses output enable low to drive
//
// Summary of operation
// RQ1: A high style strap selects the strobe bus and a low one the direction-line bus.
// RQ2: The style strap is pulled up, so a floating strap selects the strobe bus.
// RQ3: In direction-line style the write strobe is read/write, reset is active low, read strobe is ignored.
// RQ4: In direction-line style the four channel interrupts are ORed onto one open-source request.
// RQ5: The three low address bits pick the register of the accessed channel in both styles.
// RQ6: In direction-line style the two upper address bits pick the channel while the shared select is low.
// RQ7: In strobe style the two upper address inputs are the low-active selects of channels B and C.
// RQ8: In direction-line style a low shared select enables all channels, the address bits name the one used.
// RQ9: In strobe style the shared select is the low-active select of channel A only.
// RQ10: In strobe style only the channel whose own select is low takes part in a transfer.
// RQ11: In strobe style each channel drives its own high interrupt when gated, enabled and pending.
// RQ12: In direction-line style upper address values 00, 01, 10, 11 pick channels A, B, C, D.
// RQ13: With no channel selected the data bus is released and address and strobes are ignored.
`timescale 1ns/100ps
module quhbs_top
(
  // Clock and reset
  clk,
  rst,
  // Host bus pins
  busStyleLevel,
  busStyleFloat,
  chanASelect_n,
  channelAddrBits,
  chanDSelect_n,
  regAddrBits,
  readStrobe_n,
  writeStrobe_n,
  resetPin,
  dataIn,
  dataOut,
  dataOe_n,
  // Channel side
  chanRdData,
  chanIntGate,
  chanIntEnable,
  chanIntPending,
  chanSel,
  regAddr,
  wrData,
  wrPulse,
  rdPulse,
  uartReset,
  modeIsStrobe,
  // Interrupt pins
  chanIntOut,
  irqOut,
  irqOe_n
);
  // Clock and reset
  input  wire logic                                            clk;
  input  wire logic                                            rst;
  // Host bus pins
  input  wire logic                                            busStyleLevel;
  input  wire logic                                            busStyleFloat;
  input  wire logic                                            chanASelect_n;
  input  wire logic [quhbs_pkg::CHAN_AW-1:0]                   channelAddrBits;
  input  wire logic                                            chanDSelect_n;
  input  wire logic [quhbs_pkg::REG_AW-1:0]                    regAddrBits;
  input  wire logic                                            readStrobe_n;
  input  wire logic                                            writeStrobe_n;
  input  wire logic                                            resetPin;
  input  wire logic [quhbs_pkg::DATA_W-1:0]                    dataIn;
  output logic      [quhbs_pkg::DATA_W-1:0]                    dataOut;
  output logic                                                 dataOe_n;
  // Channel side
  input  wire logic [quhbs_pkg::NUM_CHAN-1:0][quhbs_pkg::DATA_W-1:0] chanRdData;
  input  wire logic [quhbs_pkg::NUM_CHAN-1:0]                  chanIntGate;
  input  wire logic [quhbs_pkg::NUM_CHAN-1:0]                  chanIntEnable;
  input  wire logic [quhbs_pkg::NUM_CHAN-1:0]                  chanIntPending;
  output logic      [quhbs_pkg::NUM_CHAN-1:0]                  chanSel;
  output logic      [quhbs_pkg::REG_AW-1:0]                    regAddr;
  output logic      [quhbs_pkg::DATA_W-1:0]                    wrData;
  output logic                                                 wrPulse;
  output logic                                                 rdPulse;
  output logic                                                 uartReset;
  output logic                                                 modeIsStrobe;
  // Interrupt pins
  output logic      [quhbs_pkg::NUM_CHAN-1:0]                  chanIntOut;
  output logic                                                 irqOut;
  output logic                                                 irqOe_n;

  // Channel number to one-hot select
  function automatic logic [quhbs_pkg::NUM_CHAN-1:0] quhbs_onehot
  (
    input logic [quhbs_pkg::CHAN_AW-1:0] idx
  );
    quhbs_onehot = 4'h1 << idx;
  endfunction : quhbs_onehot

  // Lowest selected channel for read data
  function automatic logic [quhbs_pkg::CHAN_AW-1:0] quhbs_first
  (
    input logic [quhbs_pkg::NUM_CHAN-1:0] sel
  );
    quhbs_first = sel[0] ? quhbs_pkg::CHAN_A :
                  sel[1] ? quhbs_pkg::CHAN_B :
                  sel[2] ? quhbs_pkg::CHAN_C : quhbs_pkg::CHAN_D;
  endfunction : quhbs_first

  // Pin synchroniser
  quhbs_pin_if pinBus ();

  assign pinBus.raw = {dataIn, resetPin, writeStrobe_n, readStrobe_n, regAddrBits,
                       chanDSelect_n, channelAddrBits, chanASelect_n, busStyleFloat,
                       busStyleLevel};

  quhbs_pin_sync uPinSync
  (
    .clk  (clk),
    .rst  (rst),
    .pins (pinBus.sync)
  );

  // Synced pin fields
  wire logic                          styleLvlS  = pinBus.synced[quhbs_pkg::PIN_STYLE_LVL];
  wire logic                          styleFltS  = pinBus.synced[quhbs_pkg::PIN_STYLE_FLT];
  wire logic                          csSharedS  = pinBus.synced[quhbs_pkg::PIN_CS_SHARED];
  wire logic [quhbs_pkg::CHAN_AW-1:0] chanAddrS  =
    pinBus.synced[quhbs_pkg::PIN_CHAN_ADDR +: quhbs_pkg::CHAN_AW];
  wire logic                          csDS       = pinBus.synced[quhbs_pkg::PIN_CS_D];
  wire logic [quhbs_pkg::REG_AW-1:0]  regAddrS   =
    pinBus.synced[quhbs_pkg::PIN_REG_ADDR +: quhbs_pkg::REG_AW];
  wire logic                          rdStbS     = pinBus.synced[quhbs_pkg::PIN_RD_STB];
  wire logic                          wrStbS     = pinBus.synced[quhbs_pkg::PIN_WR_STB];
  wire logic                          resetPinS  = pinBus.synced[quhbs_pkg::PIN_RESET];
  wire logic [quhbs_pkg::DATA_W-1:0]  dataS      =
    pinBus.synced[quhbs_pkg::PIN_DATA +: quhbs_pkg::DATA_W];

  // Bus style and select decode
  wire logic styleStrobe = styleLvlS | styleFltS;                    // RQ1 RQ2
  wire logic [quhbs_pkg::NUM_CHAN-1:0] selStrobe =
    {~csDS, ~chanAddrS[1], ~chanAddrS[0], ~csSharedS};                // RQ7 RQ9 RQ10
  wire logic [quhbs_pkg::NUM_CHAN-1:0] selDir =
    csSharedS ? 4'h0 : quhbs_onehot(chanAddrS);                       // RQ6 RQ8 RQ12
  wire logic [quhbs_pkg::NUM_CHAN-1:0] selNow = styleStrobe ? selStrobe : selDir;
  wire logic anySel = |selNow;
  wire logic rdReq  = anySel & (styleStrobe ? ~rdStbS : wrStbS);      // RQ3 RQ13
  wire logic wrReq  = anySel & ~wrStbS;                               // RQ3 RQ13

  // Interrupt routing
  wire logic [quhbs_pkg::NUM_CHAN-1:0] intCond = chanIntEnable & chanIntPending;
  wire logic [quhbs_pkg::NUM_CHAN-1:0] intGated = chanIntGate & intCond;

  // Access sequencer
  quhbs_pkg::quhbs_state_t state_r;
  quhbs_pkg::quhbs_state_t state_nxt;
  logic [quhbs_pkg::NUM_CHAN-1:0] selHeld_r;
  logic [quhbs_pkg::NUM_CHAN-1:0] selHeld_nxt;

  always_comb
  begin
    state_nxt   = state_r;
    selHeld_nxt = selHeld_r;
    unique case (state_r)
      quhbs_pkg::QUHBS_IDLE:
      begin
        selHeld_nxt = selNow;
        if (wrReq)
          state_nxt = quhbs_pkg::QUHBS_WRITE;
        else if (rdReq)
          state_nxt = quhbs_pkg::QUHBS_READ;
      end
      quhbs_pkg::QUHBS_READ:
        if (!rdReq)
          state_nxt = quhbs_pkg::QUHBS_IDLE;
      quhbs_pkg::QUHBS_WRITE:
        if (!wrReq)
          state_nxt = quhbs_pkg::QUHBS_IDLE;
      default:
        state_nxt = quhbs_pkg::QUHBS_IDLE;
    endcase
  end

  wire logic inIdle   = (state_r == quhbs_pkg::QUHBS_IDLE);
  wire logic readNext = (state_nxt == quhbs_pkg::QUHBS_READ);
  wire logic [quhbs_pkg::DATA_W-1:0] rdMux = chanRdData[quhbs_first(selHeld_nxt)];

  // Sequencer registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r   <= quhbs_pkg::QUHBS_IDLE;
      selHeld_r <= 4'h0;
    end
    else
    begin
      state_r   <= state_nxt;
      selHeld_r <= selHeld_nxt;
    end
  end

  // Channel side outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      chanSel <= 4'h0;
      regAddr <= 3'h0;
      wrData  <= 8'h00;
      wrPulse <= 1'b0;
      rdPulse <= 1'b0;
    end
    else
    begin
      chanSel <= (state_nxt == quhbs_pkg::QUHBS_IDLE) ? 4'h0 : selHeld_nxt; // RQ10 RQ13
      regAddr <= inIdle ? regAddrS : regAddr;                                // RQ5
      wrData  <= inIdle ? dataS : wrData;
      wrPulse <= inIdle & wrReq;
      rdPulse <= inIdle & ~wrReq & rdReq;
    end
  end

  // Host data bus and mode outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dataOut      <= 8'h00;
      dataOe_n     <= 1'b1;
      uartReset    <= 1'b1;
      modeIsStrobe <= quhbs_pkg::STYLE_STROBE;
    end
    else
    begin
      dataOut      <= readNext ? rdMux : 8'h00;
      dataOe_n     <= ~readNext;                                    // RQ13
      uartReset    <= styleStrobe ? resetPinS : ~resetPinS;         // RQ3
      modeIsStrobe <= styleStrobe;                                  // RQ1
    end
  end

  // Interrupt outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      chanIntOut <= 4'h0;
      irqOut     <= 1'b0;
      irqOe_n    <= 1'b1;
    end
    else
    begin
      chanIntOut <= modeIsStrobe ? intGated : 4'h0;                 // RQ11
      irqOut     <= ~modeIsStrobe & (|intCond);                     // RQ4
      irqOe_n    <= ~(~modeIsStrobe & (|intCond));                  // RQ4
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_style_strap_sel: assert property ( // RQ1
    ##3 (!$past(busStyleFloat, 3)) |-> (modeIsStrobe == $past(busStyleLevel, 3)))
    else $error("bus style does not follow strap");
  a_float_pulls_up: assert property ( // RQ2
    ##3 $past(busStyleFloat, 3) |-> modeIsStrobe)
    else $error("floating strap did not select strobe style");
  a_reset_polarity: assert property ( // RQ3
    ##3 modeIsStrobe |-> (uartReset == $past(resetPin, 3)))
    else $error("strobe style reset polarity wrong");
  a_reset_active_low: assert property ( // RQ3
    ##3 !modeIsStrobe |-> (uartReset == !$past(resetPin, 3)))
    else $error("direction style reset polarity wrong");
  a_irq_wire_or: assert property ( // RQ4
    ##1 (!$past(modeIsStrobe) && |$past(intCond)) |-> (irqOut && !irqOe_n && chanIntOut == 4'h0))
    else $error("combined interrupt not driven");
  a_reg_addr_hold: assert property ( // RQ5
    (wrPulse || rdPulse) |-> (regAddr == $past(regAddrS)))
    else $error("register address not passed through");
  a_dir_chan_pick: assert property ( // RQ6
    (wrPulse && !modeIsStrobe && $past(!styleStrobe)) |-> (chanSel == quhbs_onehot($past(chanAddrS))))
    else $error("channel pick by address bits wrong");
  a_strobe_sel_map: assert property ( // RQ7
    (wrPulse && $past(styleStrobe)) |-> (chanSel == $past(selStrobe)))
    else $error("strobe style selects mismapped");
  a_int_per_chan: assert property ( // RQ11
    ##1 $past(modeIsStrobe) |-> (chanIntOut == $past(intGated) && irqOe_n))
    else $error("per channel interrupt wrong");
  a_idle_release: assert property ( // RQ13
    (chanSel == 4'h0) |-> (dataOe_n && !wrPulse && !rdPulse))
    else $error("bus driven without a selected channel");

  c_strobe_write: cover property (wrPulse && modeIsStrobe);
  c_strobe_read:  cover property (rdPulse && modeIsStrobe ##1 !dataOe_n);
  c_dir_write:    cover property (wrPulse && !modeIsStrobe);
  c_dir_irq:      cover property (!irqOe_n);

endmodule : quhbs_top

//--- rtl/quhbs_pkg.sv
// Purpose: Shared constants and types of the quad UART host bus front end
// Assumes: Four channels, eight-bit data bus, three register address bits
// Notes:   Pin bundle positions describe the vector passed to the synchroniser
package quhbs_pkg;

  // Bus geometry
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned CHAN_AW  = 2;
  localparam int unsigned REG_AW   = 3;
  localparam int unsigned DATA_W   = 8;

  // Bus style strap levels
  localparam logic STYLE_STROBE  = 1'b1;
  localparam logic STYLE_DIRLINE = 1'b0;

  // Channel numbers
  localparam logic [CHAN_AW-1:0] CHAN_A = 2'h0;
  localparam logic [CHAN_AW-1:0] CHAN_B = 2'h1;
  localparam logic [CHAN_AW-1:0] CHAN_C = 2'h2;
  localparam logic [CHAN_AW-1:0] CHAN_D = 2'h3;

  // Pin bundle layout
  localparam int unsigned PIN_STYLE_LVL = 0;
  localparam int unsigned PIN_STYLE_FLT = 1;
  localparam int unsigned PIN_CS_SHARED = 2;
  localparam int unsigned PIN_CHAN_ADDR = 3;
  localparam int unsigned PIN_CS_D      = 5;
  localparam int unsigned PIN_REG_ADDR  = 6;
  localparam int unsigned PIN_RD_STB    = 9;
  localparam int unsigned PIN_WR_STB    = 10;
  localparam int unsigned PIN_RESET     = 11;
  localparam int unsigned PIN_DATA      = 12;
  localparam int unsigned PIN_W         = 20;

  // Synchroniser reset value: idle pin levels, strobe style, nothing selected
  localparam logic [PIN_W-1:0] SYNC_RST = 20'h0063D;

  // Access sequencer states
  typedef enum logic [2:0]
  {
    QUHBS_IDLE  = 3'h1,
    QUHBS_READ  = 3'h2,
    QUHBS_WRITE = 3'h4
  } quhbs_state_t;

endpackage : quhbs_pkg

//--- rtl/quhbs_pin_if.sv
// Purpose: Carries raw host pins into the synchroniser and synced copies back
// Assumes: One clock domain on the synced side
// Notes:   Layout of the vector is given in the package
`timescale 1ns/100ps
interface quhbs_pin_if;
  logic [quhbs_pkg::PIN_W-1:0] raw;
  logic [quhbs_pkg::PIN_W-1:0] synced;

  modport sync
  (
    input  raw,
    output synced
  );

  modport user
  (
    output raw,
    input  synced
  );
endinterface : quhbs_pin_if

//--- rtl/quhbs_pin_sync.sv
// Purpose: Two flip-flop synchroniser for every host bus pin
// Assumes: Pins are asynchronous to clk
// Notes:   The first stage feeds only the second stage
`timescale 1ns/100ps
module quhbs_pin_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin bundle
  quhbs_pin_if.sync pins
);

  logic [quhbs_pkg::PIN_W-1:0] stage1_r;
  logic [quhbs_pkg::PIN_W-1:0] stage2_r;

  // Two stage capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_r <= quhbs_pkg::SYNC_RST;
      stage2_r <= quhbs_pkg::SYNC_RST;
    end
    else
    begin
      stage1_r <= pins.raw;
      stage2_r <= stage1_r;
    end
  end

  assign pins.synced = stage2_r;

endmodule : quhbs_pin_sync

//--- dv/quhbs_host_model.sv
// Purpose: Behavioural host CPU on the parallel bus of the front end
// Assumes: Pins change 1 ns after the rising clock edge
// Notes:   A released data bus shows the inverse of the last host value
`timescale 1ns/100ps
module quhbs_host_model
(
  // Clock
  input  wire logic       clk,
  // Device side of the data bus
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe_n,
  // Host pins
  output logic            chanASelect_n,
  output logic [1:0]      channelAddrBits,
  output logic            chanDSelect_n,
  output logic [2:0]      regAddrBits,
  output logic            readStrobe_n,
  output logic            writeStrobe_n,
  output logic [7:0]      dataIn
);
  logic       hostDrive = 1'b0;
  logic [7:0] hostData  = 8'h00;

  // Wire level from both enables
  assign dataIn = hostDrive ? hostData : (!dataOe_n ? dataOut : ~hostData);

  task automatic release_bus;
    chanASelect_n   = 1'b1;
    chanDSelect_n   = 1'b1;
    channelAddrBits = 2'h3;
    readStrobe_n    = 1'b1;
    writeStrobe_n   = 1'b1;
    hostDrive       = 1'b0;
  endtask : release_bus

  initial
  begin
    regAddrBits = 3'h0;
    release_bus();
  end

  // One access: address set up 3 clocks, select and strobe held 8 clocks
  task automatic access(input logic dir, input logic wr, input logic [1:0] ch,
                        input logic [2:0] ra, input logic [7:0] wd, input logic sel,
                        output logic [7:0] rd);
    @(posedge clk);
    #1;
    regAddrBits = ra;
    hostData    = wd;
    hostDrive   = wr;
    if (dir)
    begin
      channelAddrBits = ch;
      writeStrobe_n   = !wr;
      readStrobe_n    = !wr;
    end
    repeat (3) @(posedge clk);
    #1;
    if (dir)
      chanASelect_n = !sel;
    else
    begin
      {chanDSelect_n, channelAddrBits, chanASelect_n} = sel ? ~(4'h1 << ch) : 4'hF;
      readStrobe_n  = wr;
      writeStrobe_n = !wr;
    end
    repeat (8) @(posedge clk);
    #1;
    rd = dataIn;
    release_bus();
    repeat (4) @(posedge clk);
    #1;
  endtask : access
endmodule : quhbs_host_model

//--- dv/tb_quad_uart_host_bus_select.sv
// Purpose: Self-checking bench of the quad UART host bus front end
// Assumes: Host bus pins driven by the host model; style straps, reset pin and channel side by this bench
// Notes:   Pulses are counted by a monitor that keeps the last selection
`timescale 1ns/100ps
module tb_quad_uart_host_bus_select;
  logic            clk        = 1'b0;
  logic            rst        = 1'b1;
  logic            styleLvl   = 1'b1;
  logic            styleFlt   = 1'b0;
  logic            resetPin   = 1'b0;
  logic [3:0][7:0] chanRdData = {8'hD4, 8'hC3, 8'hB2, 8'hA1};
  logic [3:0]      gate       = 4'h0;
  logic [3:0]      enab       = 4'h0;
  logic [3:0]      pend       = 4'h0;
  logic            csA_n, csD_n, rdStb_n, wrStb_n, dataOe_n, wrPulse, rdPulse;
  logic            uartReset, modeIsStrobe, irqOut, irqOe_n;
  logic [1:0]      chanAddr;
  logic [2:0]      regAddrBits, regAddr, lastReg;
  logic [7:0]      dataIn, dataOut, wrData, rd, lastData;
  logic [3:0]      chanSel, chanIntOut, lastSel;
  int              n_mismatch = 0;
  int              n_compared = 0;
  int              nWr        = 0;
  int              nRd        = 0;

  quhbs_top u_dut (.clk(clk), .rst(rst), .busStyleLevel(styleLvl), .busStyleFloat(styleFlt),
    .chanASelect_n(csA_n), .channelAddrBits(chanAddr), .chanDSelect_n(csD_n),
    .regAddrBits(regAddrBits), .readStrobe_n(rdStb_n), .writeStrobe_n(wrStb_n),
    .resetPin(resetPin), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .chanRdData(chanRdData), .chanIntGate(gate), .chanIntEnable(enab),
    .chanIntPending(pend), .chanSel(chanSel), .regAddr(regAddr), .wrData(wrData),
    .wrPulse(wrPulse), .rdPulse(rdPulse), .uartReset(uartReset),
    .modeIsStrobe(modeIsStrobe), .chanIntOut(chanIntOut), .irqOut(irqOut),
    .irqOe_n(irqOe_n));

  quhbs_host_model u_host (.clk(clk), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .chanASelect_n(csA_n), .channelAddrBits(chanAddr), .chanDSelect_n(csD_n),
    .regAddrBits(regAddrBits), .readStrobe_n(rdStb_n), .writeStrobe_n(wrStb_n),
    .dataIn(dataIn));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // Pulse monitor
  always @(negedge clk)
  begin
    if (wrPulse === 1'b1 || rdPulse === 1'b1)
    begin
      lastSel  = chanSel;
      lastReg  = regAddr;
      lastData = wrData;
    end
    nWr += int'(wrPulse === 1'b1);
    nRd += int'(rdPulse === 1'b1);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic set_strap(input logic lvl, input logic flt, input logic rp);
    styleLvl = lvl;
    styleFlt = flt;
    resetPin = rp;
    repeat (6) @(posedge clk);
    #1;
  endtask : set_strap

  task automatic sc_style;
    set_strap(1'b0, 1'b1, 1'b0);
    check("float strap", 32'(modeIsStrobe), 32'h1);
    check("reset low strobe", 32'(uartReset), 32'h0);
    set_strap(1'b1, 1'b0, 1'b1);
    check("high strap", 32'(modeIsStrobe), 32'h1);
    check("reset high strobe", 32'(uartReset), 32'h1);
    set_strap(1'b0, 1'b0, 1'b1);
    check("low strap", 32'(modeIsStrobe), 32'h0);
    check("reset high dir", 32'(uartReset), 32'h0);
    set_strap(1'b0, 1'b0, 1'b0);
    check("reset low dir", 32'(uartReset), 32'h1);
  endtask : sc_style

  task automatic sc_access(input logic dir);
    int w0;
    int r0;
    set_strap(!dir, 1'b0, dir);
    for (int c = 0; c < 4; c++)
    begin
      w0 = nWr;
      r0 = nRd;
      u_host.access(dir, 1'b1, 2'(c), 3'(7 - c), 8'h3C + 8'(c), 1'b1, rd);
      check("write count", 32'(nWr - w0), 32'h1);
      check("read ignored", 32'(nRd - r0), 32'h0);
      check("write sel", 32'(lastSel), 32'(4'h1 << c));
      check("write reg", 32'(lastReg), 32'(7 - c));
      check("write data", 32'(lastData), 32'(8'h3C + 8'(c)));
      u_host.access(dir, 1'b0, 2'(c), 3'(c), 8'h00, 1'b1, rd);
      check("read count", 32'(nRd - r0), 32'h1);
      check("read sel", 32'(lastSel), 32'(4'h1 << c));
      check("read reg", 32'(lastReg), 32'(c));
      check("read data", 32'(rd), 32'(chanRdData[c]));
    end
  endtask : sc_access

  task automatic sc_no_select;
    int w0;
    int r0;
    for (int d = 0; d < 2; d++)
    begin
      set_strap(d == 0, 1'b0, d == 1);
      w0 = nWr;
      r0 = nRd;
      u_host.access(d == 1, 1'b1, 2'h2, 3'h1, 8'hFF, 1'b0, rd);
      u_host.access(d == 1, 1'b0, 2'h2, 3'h1, 8'h5A, 1'b0, rd);
      check("unselected pulses", 32'(nWr + nRd - w0 - r0), 32'h0);
      check("unselected bus", 32'(rd), 32'h000000A5);
    end
  endtask : sc_no_select

  task automatic sc_irq;
    logic [11:0] pat [4] = '{12'hFFF, 12'h5F3, 12'hAC6, 12'h3E9};
    for (int d = 0; d < 2; d++)
    begin
      set_strap(d == 0, 1'b0, d == 1);
      for (int i = 0; i < 4; i++)
      begin
        {gate, enab, pend} = pat[i];
        repeat (3) @(posedge clk);
        #1;
        if (d == 0)
        begin
          check("int lines", 32'(chanIntOut), 32'(gate & enab & pend));
          check("irq off strobe", 32'(irqOe_n), 32'h1);
          check("irq low strobe", 32'(irqOut), 32'h0);
        end
        else
        begin
          check("int lines dir", 32'(chanIntOut), 32'h0);
          check("irq drive", 32'(irqOe_n), 32'(!(|(enab & pend))));
          check("irq level", 32'(irqOut), 32'(|(enab & pend)));
        end
      end
    end
  endtask : sc_irq

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    sc_style();
    sc_access(1'b0);
    sc_access(1'b1);
    sc_no_select();
    sc_irq();
    results();
  end
endmodule : tb_quad_uart_host_bus_select
